// >>> logic/scc_pkg.sv
`default_nettype none
package scc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] MODE_OFS   = 8'h04;
   localparam logic [7:0] STAT_OFS   = 8'h08;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] MODE_RST   = 8'h00;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int TX_IRQ_BIT  = 7;
   localparam int RX_IRQ_BIT  = 6;
   localparam int TXA_BIT  = 5;
   localparam int RXA_BIT  = 4;
   localparam int AFE_BIT  = 3;
   localparam int END_IRQ_BIT = 2;
   localparam int CKH_BIT  = 1;
   localparam int CKL_BIT  = 0;

   // ----------------------------------------------------------------
   // Mode field positions
   // ----------------------------------------------------------------
   localparam int SYNC_BIT = 7;
   localparam int MPF_BIT  = 2;
   localparam int SMC_BIT  = 0;

   // ----------------------------------------------------------------
   // Pin clock roles
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCC_PIN_PORT,
      SCC_PIN_CLK_OUT,
      SCC_PIN_CLK_IN
   } scc_pin_role_t;

endpackage : scc_pkg
`default_nettype wire

// >>> logic/scc_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module scc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // Data.
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   always_comb begin
      nxt_meta = d_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign q_out = sync_ff;

endmodule : scc_sync2
`default_nettype wire

// >>> logic/scc_ctrl.sv
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module scc_ctrl (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Status conditions from the transfer engine.
   input  wire logic        tx_empty_cond,
   input  wire logic        rx_full_cond,
   input  wire logic        rx_error_cond,
   input  wire logic        tx_end_cond,
   // Received frame report from the receive engine.
   input  wire logic        rx_frame_done,
   input  wire logic        rx_frame_mpb,
   // Internal clocks.
   input  wire logic        brg_clk,
   input  wire logic        int_sync_clk,
   // Serial clock pin.
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   // Port function of the pin when it is a plain port.
   input  wire logic        port_out,
   input  wire logic        port_oe,
   output logic             port_in,
   // Engine controls.
   output logic             tx_go,
   output logic             rx_go,
   output logic             rx_store,
   output logic             ext_clk_sel,
   output logic             ext_clk,
   // Interrupt requests.
   output logic             tx_empty_irq,
   output logic             rx_full_irq,
   output logic             rx_error_irq,
   output logic             tx_end_irq
);

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic [7:0]  serial_ctrl_reg_ff;
   logic [7:0]  nxt_ctrl;
   logic [7:0]  serial_mode_reg_ff;
   logic [7:0]  nxt_mode;
   logic        wr_pend_ff;
   logic        nxt_wr_pend;
   logic [7:0]  wr_addr_ff;
   logic [7:0]  nxt_wr_addr;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;
   logic        sck_s;
   logic        smartcard_select;
   logic        async_mode;
   logic        addr_format_bit;
   logic        filt_active;
   logic        take;
   logic [7:0]  stat_word;

   scc_sync2 #(.W(1)) u_sck_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .d_in    (sck_in),
      .q_out   (sck_s)
   );

   assign smartcard_select = serial_mode_reg_ff[scc_pkg::SMC_BIT];
   assign async_mode       = ~serial_mode_reg_ff[scc_pkg::SYNC_BIT];
   assign addr_format_bit  = serial_mode_reg_ff[scc_pkg::MPF_BIT];
   // Filtering only bites in async multiprocessor format.
   assign filt_active = serial_ctrl_reg_ff[scc_pkg::AFE_BIT] & async_mode
                        & addr_format_bit & ~smartcard_select;
   assign take = hsel & hready & htrans[1];
   assign stat_word = {4'h0, tx_end_cond, rx_error_cond, rx_full_cond,
                       tx_empty_cond};

   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input logic [7:0] c,
                                          input logic [7:0] m,
                                          input logic [7:0] s);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         scc_pkg::CTRL_OFS: r = {24'h00_0000, c};
         scc_pkg::MODE_OFS: r = {24'h00_0000, m};
         scc_pkg::STAT_OFS: r = {24'h00_0000, s};
         default:           r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd_mux

   always_comb begin
      nxt_wr_pend = take & hwrite;
      nxt_wr_addr = take ? haddr[7:0] : wr_addr_ff;
      nxt_hrdata  = (take & ~hwrite) ?
                    rd_mux(haddr[7:0], serial_ctrl_reg_ff,
                           serial_mode_reg_ff, stat_word) : hrdata_ff;
      nxt_ctrl = serial_ctrl_reg_ff;
      nxt_mode = serial_mode_reg_ff;
      if (wr_pend_ff && wr_addr_ff == scc_pkg::MODE_OFS) begin
         nxt_mode = hwdata[7:0];
      end
      if (wr_pend_ff && wr_addr_ff == scc_pkg::CTRL_OFS) begin
         nxt_ctrl = hwdata[7:0];
      end
      // Hardware clear wins over a software write in the same cycle, so an
      // address frame is never missed.
      if (filt_active && rx_frame_done && rx_frame_mpb) begin
         nxt_ctrl[scc_pkg::AFE_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         serial_ctrl_reg_ff <= scc_pkg::CTRL_RST;
         serial_mode_reg_ff <= scc_pkg::MODE_RST;
         wr_pend_ff         <= 1'b0;
         wr_addr_ff         <= 8'h00;
         hrdata_ff          <= 32'h0000_0000;
      end else begin
         serial_ctrl_reg_ff <= nxt_ctrl;
         serial_mode_reg_ff <= nxt_mode;
         wr_pend_ff         <= nxt_wr_pend;
         wr_addr_ff         <= nxt_wr_addr;
         hrdata_ff          <= nxt_hrdata;
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ----------------------------------------------------------------
   // Clock pin
   // ----------------------------------------------------------------
   scc_pkg::scc_pin_role_t role;
   logic                   ckh;
   logic                   ckl;
   logic                   ext_sel_ff;
   logic                   nxt_ext_sel;
   logic                   ext_clk_ff;
   logic                   nxt_ext_clk;
   logic                   sck_out_ff;
   logic                   nxt_sck_out;
   logic                   sck_oe_ff;
   logic                   nxt_sck_oe;
   logic                   port_in_ff;
   logic                   nxt_port_in;

   assign ckh = serial_ctrl_reg_ff[scc_pkg::CKH_BIT];
   assign ckl = serial_ctrl_reg_ff[scc_pkg::CKL_BIT];

   // The pin is resampled, so an outside clock reaches the engines three
   // cycles late; it must stay well below clk_sys.
   always_comb begin
      if (ckh) begin
         role = scc_pkg::SCC_PIN_CLK_IN;
      end else if (!async_mode || ckl) begin
         role = scc_pkg::SCC_PIN_CLK_OUT;
      end else begin
         role = scc_pkg::SCC_PIN_PORT;
      end
      nxt_ext_sel = (role == scc_pkg::SCC_PIN_CLK_IN);
      nxt_ext_clk = sck_s;
      nxt_sck_out = 1'b0;
      nxt_sck_oe  = 1'b0;
      nxt_port_in = 1'b0;
      unique case (role)
         scc_pkg::SCC_PIN_PORT: begin
            nxt_sck_out = port_out;
            nxt_sck_oe  = port_oe;
            nxt_port_in = sck_s;
         end
         scc_pkg::SCC_PIN_CLK_OUT: begin
            nxt_sck_out = async_mode ? brg_clk : int_sync_clk;
            nxt_sck_oe  = 1'b1;
         end
         scc_pkg::SCC_PIN_CLK_IN: begin
            nxt_sck_out = 1'b0;
            nxt_sck_oe  = 1'b0;
         end
         default: begin
            nxt_sck_out = 1'b0;
            nxt_sck_oe  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ext_sel_ff <= 1'b0;
         ext_clk_ff <= 1'b0;
         sck_out_ff <= 1'b0;
         sck_oe_ff  <= 1'b0;
         port_in_ff <= 1'b0;
      end else begin
         ext_sel_ff <= nxt_ext_sel;
         ext_clk_ff <= nxt_ext_clk;
         sck_out_ff <= nxt_sck_out;
         sck_oe_ff  <= nxt_sck_oe;
         port_in_ff <= nxt_port_in;
      end
   end

   // ----------------------------------------------------------------
   // Engine controls and requests
   // ----------------------------------------------------------------
   logic       tx_go_ff;
   logic       nxt_tx_go;
   logic       rx_go_ff;
   logic       nxt_rx_go;
   logic       rx_store_ff;
   logic       nxt_rx_store;
   logic [3:0] irq_ff;
   logic [3:0] nxt_irq;

   always_comb begin
      nxt_tx_go = serial_ctrl_reg_ff[scc_pkg::TXA_BIT];
      nxt_rx_go = serial_ctrl_reg_ff[scc_pkg::RXA_BIT];
      // Frames with format bit zero are dropped while filtering.
      nxt_rx_store = rx_frame_done & serial_ctrl_reg_ff[scc_pkg::RXA_BIT]
                     & ~(filt_active & ~rx_frame_mpb);
      nxt_irq[0] = tx_empty_cond
                   & serial_ctrl_reg_ff[scc_pkg::TX_IRQ_BIT];
      nxt_irq[1] = rx_full_cond
                   & serial_ctrl_reg_ff[scc_pkg::RX_IRQ_BIT];
      nxt_irq[2] = rx_error_cond
                   & serial_ctrl_reg_ff[scc_pkg::RX_IRQ_BIT];
      nxt_irq[3] = tx_end_cond
                   & serial_ctrl_reg_ff[scc_pkg::END_IRQ_BIT];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_go_ff    <= 1'b0;
         rx_go_ff    <= 1'b0;
         rx_store_ff <= 1'b0;
         irq_ff      <= 4'h0;
      end else begin
         tx_go_ff    <= nxt_tx_go;
         rx_go_ff    <= nxt_rx_go;
         rx_store_ff <= nxt_rx_store;
         irq_ff      <= nxt_irq;
      end
   end

   assign tx_go        = tx_go_ff;
   assign rx_go        = rx_go_ff;
   assign rx_store     = rx_store_ff;
   assign ext_clk_sel  = ext_sel_ff;
   assign ext_clk      = ext_clk_ff;
   assign sck_out      = sck_out_ff;
   assign sck_oe       = sck_oe_ff;
   assign port_in      = port_in_ff;
   assign tx_empty_irq = irq_ff[0];
   assign rx_full_irq  = irq_ff[1];
   assign rx_error_irq = irq_ff[2];
   assign tx_end_irq   = irq_ff[3];

endmodule : scc_ctrl
`default_nettype wire

// >>> tb/scc_remote.sv
`timescale 1ns/100ps
`default_nettype none
module scc_remote (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic srst,
   // Pin parties.
   input  wire logic ext_on,
   input  wire logic sck_oe,
   input  wire logic sck_out,
   output logic      pin
);
   // ----------------------------------------------------------------
   // Far end of the serial clock pin
   // ----------------------------------------------------------------
   logic [2:0] cnt_ff;
   logic       last_ff;
   always_ff @(posedge clk_sys) begin
      cnt_ff  <= srst ? 3'h0 : cnt_ff + 3'h1;
      last_ff <= srst ? 1'b0 : pin;
   end
   // The far clock is slow against clk_sys so the two flop sync keeps up.
   // Taken as an eighth of clk_sys; a released pin keeps toggling.
   always_comb begin
      if (sck_oe) begin
         pin = sck_out;
      end else if (ext_on) begin
         pin = cnt_ff[2];
      end else begin
         pin = ~last_ff;
      end
   end
endmodule : scc_remote
`default_nettype wire

// >>> tb/scc_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module scc_ctrl_chk (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic srst,
   // Watched ports.
   input  wire logic hreadyout,
   input  wire logic hresp,
   input  wire logic tx_empty_cond,
   input  wire logic rx_full_cond,
   input  wire logic rx_error_cond,
   input  wire logic tx_end_cond,
   input  wire logic rx_frame_done,
   input  wire logic rx_store,
   input  wire logic ext_clk_sel,
   input  wire logic sck_oe,
   input  wire logic tx_empty_irq,
   input  wire logic rx_full_irq,
   input  wire logic rx_error_irq,
   input  wire logic tx_end_irq
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_bus_zero_wait: assert property (hreadyout)
      else $error("hreadyout low");
   a_bus_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_tx_irq_cause: assert property (
      tx_empty_irq |-> $past(tx_empty_cond)) else $error("tx empty irq");
   a_rx_irq_cause: assert property (
      rx_full_irq |-> $past(rx_full_cond)) else $error("rx full irq");
   a_err_irq_cause: assert property (
      rx_error_irq |-> $past(rx_error_cond)) else $error("rx error irq");
   a_end_irq_cause: assert property (
      tx_end_irq |-> $past(tx_end_cond)) else $error("tx end irq");
   a_store_after_frame: assert property (
      rx_store |-> $past(rx_frame_done)) else $error("store without frame");
   a_ext_pin_input: assert property (
      ext_clk_sel |-> !sck_oe) else $error("pin driven in clock input");
endmodule : scc_ctrl_chk
bind scc_ctrl scc_ctrl_chk u_chk (.clk_sys, .srst, .hreadyout, .hresp,
   .tx_empty_cond, .rx_full_cond, .rx_error_cond, .tx_end_cond,
   .rx_frame_done, .rx_store, .ext_clk_sel, .sck_oe, .tx_empty_irq,
   .rx_full_irq, .rx_error_irq, .tx_end_irq);
`default_nettype wire

// >>> tb/tb_scc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_scc_ctrl;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk_sys = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  cond = 4'h0, irq;
   logic        done = 1'b0, mpb = 1'b0, brg = 1'b1, isc = 1'b0;
   logic        p_out = 1'b0, p_oe = 1'b1, ext_on = 1'b0;
   logic        hreadyout, hresp, tx_go, rx_go, rx_store, sel, ext_clk;
   logic        p_in, pin, s_out, s_oe, e0;
   int          err_count = 0, total_checks = 0, cyc = 0;
   logic [7:0]  en_tab [3] = '{8'h80, 8'h40, 8'h04};
   logic [3:0]  irq_tab [3] = '{4'h1, 4'h6, 4'h8};
   always #50 clk_sys = ~clk_sys;
   scc_ctrl DUT (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .tx_empty_cond(cond[0]), .rx_full_cond(cond[1]),
      .rx_error_cond(cond[2]), .tx_end_cond(cond[3]), .rx_frame_done(done),
      .rx_frame_mpb(mpb), .brg_clk(brg), .int_sync_clk(isc), .sck_in(pin),
      .sck_out(s_out), .sck_oe(s_oe), .port_out(p_out), .port_oe(p_oe),
      .port_in(p_in), .tx_go(tx_go), .rx_go(rx_go), .rx_store(rx_store),
      .ext_clk_sel(sel), .ext_clk(ext_clk), .tx_empty_irq(irq[0]),
      .rx_full_irq(irq[1]), .rx_error_irq(irq[2]), .tx_end_irq(irq[3]));
   scc_remote u_far (.clk_sys(clk_sys), .srst(srst), .ext_on(ext_on),
      .sck_oe(s_oe), .sck_out(s_out), .pin(pin));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(string n, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask : xfer
   task automatic rdc(logic [7:0] a, logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check("read data", e, rd);
   endtask : rdc
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle
   task automatic frame(logic b, logic e);
      @(posedge clk_sys);
      done <= 1'b1;
      mpb <= b;
      @(posedge clk_sys);
      done <= 1'b0;
      #1 check("rx_store", e, rx_store);
   endtask : frame
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      rdc(scc_pkg::CTRL_OFS, 32'h0);
      rdc(scc_pkg::MODE_OFS, 32'h0);
      xfer(1'b1, 8'h0c, 32'hff);
      rdc(8'h0c, 32'h0);
      xfer(1'b1, scc_pkg::CTRL_OFS, 32'hf4);
      rdc(scc_pkg::CTRL_OFS, 32'hf4);
      cond <= 4'hf;
      settle;
      check("tx_go", 1'b1, tx_go);
      check("rx_go", 1'b1, rx_go);
      check("irq all", 4'hf, irq);
      rdc(scc_pkg::STAT_OFS, 32'hf);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, scc_pkg::CTRL_OFS, {24'h0, en_tab[i]});
         settle;
         check("irq gated", irq_tab[i], irq);
      end
      check("tx_go", 1'b0, tx_go);
      check("rx_go", 1'b0, rx_go);
      frame(1'b1, 1'b0);
      xfer(1'b1, scc_pkg::MODE_OFS, 32'h04);
      xfer(1'b1, scc_pkg::CTRL_OFS, 32'h18);
      frame(1'b0, 1'b0);
      rdc(scc_pkg::CTRL_OFS, 32'h18);
      frame(1'b1, 1'b1);
      rdc(scc_pkg::CTRL_OFS, 32'h10);
      frame(1'b0, 1'b1);
      xfer(1'b1, scc_pkg::MODE_OFS, 32'h84);
      xfer(1'b1, scc_pkg::CTRL_OFS, 32'h18);
      frame(1'b0, 1'b1);
      xfer(1'b1, scc_pkg::MODE_OFS, 32'h05);
      frame(1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, scc_pkg::MODE_OFS, {24'h0, i[2], 7'h0});
         xfer(1'b1, scc_pkg::CTRL_OFS, {30'h0, i[1:0]});
         ext_on <= i[1];
         settle;
         check("clk input", i[1], sel);
         check("pin drive", !i[1], s_oe);
         if (!i[1]) begin
            check("pin out", i[2:0] == 3'h1, s_out);
         end else begin
            repeat (4) @(posedge clk_sys);
            #1 e0 = ext_clk;
            repeat (4) @(posedge clk_sys);
            #1 check("ext clk", !e0, ext_clk);
         end
      end
      xfer(1'b1, scc_pkg::MODE_OFS, 32'h0);
      xfer(1'b1, scc_pkg::CTRL_OFS, 32'h0);
      p_out <= 1'b1;
      settle;
      settle;
      check("port out", 1'b1, s_out);
      check("port in", 1'b1, p_in);
      xfer(1'b1, scc_pkg::CTRL_OFS, 32'h30);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rdc(scc_pkg::CTRL_OFS, 32'h0);
      check("rx_go", 1'b0, rx_go);
      report_and_stop;
   end
endmodule : tb_scc_ctrl
`default_nettype wire
